/* File: spi_bit_sync.sv */
`default_nettype none

module spi_bit_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // The first stage feeds only the second stage.
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = i_d;
    r_next.s2 = r_reg.s1;
  end

  // Both stages clear on synchronous reset.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_q = r_reg.s2;

endmodule : spi_bit_sync

`default_nettype wire

/* File: spi_far_end.sv */
`default_nettype none

module spi_far_end (
  // Serial pins as seen from the far side.
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  input  wire logic i_sel_n,
  // Far side drive; the clock rests low outside frames.
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_miso
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sr;
  logic       bit_in;

  // Starts idle with a known slave word.
  initial begin
    o_sck = 1'h0;
    o_mosi = 1'h0;
    sr = 8'h00;
    bit_in = 1'h0;
  end

  // Slave half samples on the rising clock and shifts on the falling one.
  always @(posedge i_sck) begin
    bit_in = i_mosi;
  end

  always @(negedge i_sck) begin
    if (!i_sel_n) begin
      sr = {sr[6:0], bit_in};
    end
  end

  // An unselected slave shows the opposite of its top bit, never a held copy.
  assign o_miso = i_sel_n ? ~sr[7] : sr[7];

  // Master half sends one byte on a 48 ns clock, top bit first.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #24;
      rx[i] = i_miso;
      o_sck = 1'h1;
      #24;
      o_sck = 1'h0;
    end
    o_mosi = ~o_mosi;
  endtask : xfer
endmodule : spi_far_end

`default_nettype wire

/* File: spi_link_if.sv */
`default_nettype none

// Signals between the system-clock core and the slave logic on the link clock.
interface spi_link_if;
  logic [7:0] tx_hold;
  logic [7:0] rx_hold;
  logic       done_tog;
  logic       miso_bit;

  modport core (
    output tx_hold,
    input  rx_hold,
    input  done_tog,
    input  miso_bit
  );

  modport link (
    input  tx_hold,
    output rx_hold,
    output done_tog,
    output miso_bit
  );
endinterface : spi_link_if

`default_nettype wire

/* File: spi_link_slave.sv */
`default_nettype none

module spi_link_slave
  import spi_pkg::*;
(
  // Link clock from the external master and the frame reset.
  input  wire logic i_link_sck,
  input  wire logic i_link_rst,
  // Serial data from the external master.
  input  wire logic i_mosi,
  // Exchange with the system-clock core.
  spi_link_if.link  lnk
);

  typedef struct packed {
    logic [7:0] sr;
    logic [2:0] cnt;
    logic [7:0] rx_hold;
    logic       done_tog;
    logic       loaded;
  } link_s;

  link_s      r_reg;
  link_s      r_next;
  logic [7:0] shift_src;

  // Before the first edge of a frame the outgoing byte comes straight from the hold register.
  assign shift_src = r_reg.loaded ? r_reg.sr : lnk.tx_hold;

  // Sample on every rising edge, capture each full byte and reload the next one.
  always_comb begin
    r_next        = r_reg;
    r_next.loaded = 1'b1;
    r_next.sr     = {shift_src[MSB_IDX-1:0], i_mosi};
    r_next.cnt    = r_reg.cnt + 3'h1;
    if (r_reg.cnt == LAST_BIT) begin
      r_next.rx_hold  = {shift_src[MSB_IDX-1:0], i_mosi};
      r_next.done_tog = ~r_reg.done_tog;
      r_next.loaded   = 1'b0;
      r_next.cnt      = FIRST_BIT;
    end
  end

  // The frame reset is asynchronous because the link clock stops outside frames.
  always_ff @(posedge i_link_sck or posedge i_link_rst) begin
    if (i_link_rst) begin
      r_reg <= '{sr: BYTE_RESET, cnt: FIRST_BIT, rx_hold: BYTE_RESET,
                 done_tog: 1'b0, loaded: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outgoing bit is the top of the shift register, or of the hold register before the first edge of a byte.
  assign lnk.miso_bit = shift_src[MSB_IDX];
  assign lnk.rx_hold  = r_reg.rx_hold;
  assign lnk.done_tog = r_reg.done_tog;

endmodule : spi_link_slave

`default_nettype wire

/* File: spi_pin_and_select_modes.sv */

`default_nettype none

module spi_pin_and_select_modes #(
  parameter int SCK_HALF = spi_pkg::SCK_HALF_CYC
) (
  // System clock and synchronous reset.
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  // Configuration.
  input  wire logic                  i_spi_enable,
  input  wire logic                  i_master_mode,
  input  wire logic [1:0]            i_select_mode_field,
  // Transmit word in, receive word out.
  input  wire logic [7:0]            i_tx_data,
  input  wire logic                  i_tx_valid,
  output logic                       o_tx_ready,
  output logic [7:0]                 o_rx_data,
  output logic                       o_rx_valid,
  // Status.
  output logic                       o_busy,
  output logic                       o_slave_selected,
  output logic                       o_mode_fault,
  input  wire logic                  i_fault_clear,
  output logic                       o_nss_pin_mapped,
  // Serial clock pin; the input is the link clock of the slave logic.
  input  wire logic                  i_link_sck,
  output logic                       o_sck,
  output logic                       o_sck_oe,
  // Master-to-slave data pin.
  input  wire logic                  i_mosi,
  output logic                       o_mosi,
  output logic                       o_mosi_oe,
  // Slave-to-master data pin.
  input  wire logic                  i_miso,
  output logic                       o_miso,
  output logic                       o_miso_oe,
  // Slave-select pin.
  input  wire logic                  i_nss,
  output logic                       o_nss,
  output logic                       o_nss_oe
);

  import spi_pkg::*;

  localparam int DIV_W = (SCK_HALF > 1) ? $clog2(SCK_HALF) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  // Whole state of the core in one record.
  typedef struct packed {
    master_state_e    mstate;
    logic [DIV_W-1:0] div_cnt;
    logic [2:0]       bit_cnt;
    logic [7:0]       sr;
    logic             sck;
    logic [7:0]       rx_data;
    logic             rx_valid;
    logic [7:0]       tx_hold;
    logic             fault;
    logic             nss_q;
    logic             done_q;
  } core_s;

  localparam core_s CORE_RESET = '{
    mstate:   M_IDLE,
    div_cnt:  DIV_ZERO,
    bit_cnt:  FIRST_BIT,
    sr:       BYTE_RESET,
    sck:      1'b0,
    rx_data:  BYTE_RESET,
    rx_valid: 1'b0,
    tx_hold:  BYTE_RESET,
    fault:    1'b0,
    nss_q:    1'b1,
    done_q:   1'b0
  };

  core_s              r_reg;
  core_s              r_next;
  spi_link_if         lnk ();

  // Decoded configuration.
  logic               three_wire;
  logic               four_wire_in;
  logic               nss_is_output;
  logic               is_master;
  logic               is_slave;

  // Synchronised pin levels and link events.
  logic [SYNC_W-1:0]  sync_in;
  logic [SYNC_W-1:0]  sync_out;
  logic               miso_s;
  logic               nss_s;
  logic               done_s;

  // Derived conditions.
  logic               slave_selected;
  logic               mm_fall;
  logic               master_abort;
  logic               master_start;
  logic               link_rst;
  logic               slave_rx_event;

  // Select-mode decode.
  assign three_wire    = (i_select_mode_field == SEL_3WIRE);
  assign four_wire_in  = (i_select_mode_field == SEL_4WIRE_IN);
  assign nss_is_output = i_select_mode_field[SEL_HIGH_BIT];
  assign is_master     = i_spi_enable & i_master_mode;
  assign is_slave      = i_spi_enable & ~i_master_mode;

  // MISO, select and the link toggle pass two flip-flops before the core logic reads them; the slave reset reads raw select.
  // Select travels inverted, so a cleared synchroniser reads as the idle high level.
  // Without this, a false falling select edge would follow every reset.
  assign sync_in[SYNC_MISO] = i_miso;
  assign sync_in[SYNC_NSS]  = ~i_nss;
  assign sync_in[SYNC_DONE] = lnk.done_tog;

  spi_bit_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk (i_sys_clk),
    .i_rst (i_sys_rst),
    .i_d   (sync_in),
    .o_q   (sync_out)
  );

  assign miso_s = sync_out[SYNC_MISO];
  assign nss_s  = ~sync_out[SYNC_NSS];
  assign done_s = sync_out[SYNC_DONE];

  // A 3-wire slave is always selected; a 4-wire input-mode slave only while select is low.
  // The upper select modes are meant for a master, so a slave there is never selected.
  assign slave_selected = is_slave & (three_wire | (four_wire_in & ~nss_s));

  // Another master pulling select low while this one is in mode 01.
  assign mm_fall = is_master & four_wire_in & r_reg.nss_q & ~nss_s;

  // The master sequencer stops as soon as it loses the right to drive the bus.
  assign master_abort = ~is_master | mm_fall | r_reg.fault;

  // A new master word starts when idle, allowed and offered.
  assign master_start = is_master & i_tx_valid & ~r_reg.fault & ~mm_fall;

  // The slave logic is held in reset outside a selected frame, so clock edges are ignored.
  assign link_rst = i_sys_rst | ~is_slave | nss_is_output |
                    (four_wire_in & i_nss);

  // A completed slave byte is seen as a change of the synchronised toggle.
  // Deselect resets the toggle, and that change arrives together with the synchronised
  // select, so gating with the selection drops the false byte it would otherwise cause.
  assign slave_rx_event = slave_selected & (done_s != r_reg.done_q);

  // Slave logic on the external serial clock.
  spi_link_slave u_link (
    .i_link_sck (i_link_sck),
    .i_link_rst (link_rst),
    .i_mosi     (i_mosi),
    .lnk        (lnk.link)
  );

  // The slave takes its next byte from the hold register at byte boundaries.
  assign lnk.tx_hold = r_reg.tx_hold;

  // Next-state logic of the core.
  always_comb begin
    r_next          = r_reg;
    r_next.rx_valid = 1'b0;
    r_next.nss_q    = nss_s;
    r_next.done_q   = done_s;

    // Slave receive: the link byte is stable for a whole byte time after the toggle.
    if (slave_rx_event) begin
      r_next.rx_data  = lnk.rx_hold;
      r_next.rx_valid = 1'b1;
    end

    // Slave transmit word waits in the hold register.
    if (is_slave && i_tx_valid) begin
      r_next.tx_hold = i_tx_data;
    end

    // Fault flag: a falling select edge wins over a clear in the same cycle.
    if (i_fault_clear) begin
      r_next.fault = 1'b0;
    end
    if (mm_fall) begin
      r_next.fault = 1'b1;
    end

    // Master shift sequencer in serial clock mode 0: low half, high half, shift on the fall.
    // Sampling at the fall gives the far slave a whole high half to settle its output
    // through the two synchroniser stages.
    case (r_reg.mstate)
      M_IDLE: begin
        r_next.sck     = 1'b0;
        r_next.div_cnt = DIV_ZERO;
        if (master_start) begin
          r_next.sr      = i_tx_data;
          r_next.bit_cnt = FIRST_BIT;
          r_next.mstate  = M_LOW;
        end
      end
      M_LOW: begin
        if (master_abort) begin
          r_next.sck    = 1'b0;
          r_next.mstate = M_IDLE;
        end else if (r_reg.div_cnt == DIV_LAST) begin
          r_next.div_cnt = DIV_ZERO;
          r_next.sck     = 1'b1;
          r_next.mstate  = M_HIGH;
        end else begin
          r_next.div_cnt = r_reg.div_cnt + DIV_W'(1);
        end
      end
      M_HIGH: begin
        if (master_abort) begin
          r_next.sck    = 1'b0;
          r_next.mstate = M_IDLE;
        end else if (r_reg.div_cnt == DIV_LAST) begin
          r_next.div_cnt = DIV_ZERO;
          r_next.sck     = 1'b0;
          r_next.sr      = {r_reg.sr[MSB_IDX-1:0], miso_s};
          if (r_reg.bit_cnt == LAST_BIT) begin
            r_next.rx_data  = {r_reg.sr[MSB_IDX-1:0], miso_s};
            r_next.rx_valid = 1'b1;
            r_next.mstate   = M_IDLE;
          end else begin
            r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
            r_next.mstate  = M_LOW;
          end
        end else begin
          r_next.div_cnt = r_reg.div_cnt + DIV_W'(1);
        end
      end
      default: begin
        r_next.sck    = 1'b0;
        r_next.mstate = M_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      r_reg <= CORE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Word handshake and status.
  assign o_tx_ready       = is_slave |
                            (is_master & ~r_reg.fault & (r_reg.mstate == M_IDLE));
  assign o_rx_data        = r_reg.rx_data;
  assign o_rx_valid       = r_reg.rx_valid;
  assign o_busy           = (r_reg.mstate != M_IDLE);
  assign o_slave_selected = slave_selected;
  assign o_mode_fault     = r_reg.fault;

  // The crossbar routes the select pin in every mode except the 3-wire one.
  assign o_nss_pin_mapped = ~three_wire;

  // Serial clock is driven only by an active master.
  assign o_sck    = r_reg.sck;
  assign o_sck_oe = is_master & ~r_reg.fault;

  // Master-to-slave line: output as master from the top of the shift register.
  assign o_mosi    = r_reg.sr[MSB_IDX];
  assign o_mosi_oe = is_master & ~r_reg.fault;

  // Slave-to-master line: driven only by a selected slave, floating otherwise.
  assign o_miso    = lnk.miso_bit;
  assign o_miso_oe = slave_selected;

  // Select pin drives the lower select bit in the output modes.
  assign o_nss    = i_select_mode_field[SEL_LOW_BIT];
  assign o_nss_oe = i_spi_enable & nss_is_output;

endmodule : spi_pin_and_select_modes

`default_nettype wire

/* File: spi_pin_and_select_modes_test.sv */
`default_nettype none

module spi_pin_and_select_modes_test;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_pkg::*;

  logic       i_sys_clk, i_sys_rst, i_spi_enable, i_master_mode, i_tx_valid, i_fault_clear;
  logic [1:0] i_select_mode_field;
  logic [7:0] i_tx_data, o_rx_data;
  logic       o_tx_ready, o_rx_valid, o_busy, o_slave_selected, o_mode_fault, o_nss_pin_mapped;
  logic       o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_nss, o_nss_oe;
  logic       f_sck, f_mosi, f_miso, far_nss, slv_sel_n;
  logic [7:0] rxq[$];
  int         n_fail, n_checks;

  // Line levels from whichever party drives each pin.
  wire logic i_link_sck = o_sck_oe ? o_sck : f_sck;
  wire logic i_mosi = o_mosi_oe ? o_mosi : f_mosi;
  wire logic i_miso = o_miso_oe ? o_miso : f_miso;
  wire logic i_nss = o_nss_oe ? o_nss : far_nss;
  wire logic far_sel_n = o_nss_oe ? o_nss : slv_sel_n;

  spi_pin_and_select_modes #(.SCK_HALF(4)) u_spi_pin_and_select_modes (
    .i_sys_clk, .i_sys_rst, .i_spi_enable, .i_master_mode, .i_select_mode_field,
    .i_tx_data, .i_tx_valid, .o_tx_ready, .o_rx_data, .o_rx_valid, .o_busy,
    .o_slave_selected, .o_mode_fault, .i_fault_clear, .o_nss_pin_mapped, .i_link_sck,
    .o_sck, .o_sck_oe, .i_mosi, .o_mosi, .o_mosi_oe, .i_miso, .o_miso, .o_miso_oe,
    .i_nss, .o_nss, .o_nss_oe
  );

  spi_far_end u_spi_far_end (
    .i_sck(i_link_sck), .i_mosi, .i_miso, .i_sel_n(far_sel_n),
    .o_sck(f_sck), .o_mosi(f_mosi), .o_miso(f_miso)
  );

  always #4 i_sys_clk = ~i_sys_clk;

  // Collects every received byte as it is flagged.
  always @(posedge i_sys_clk) begin
    if (o_rx_valid === 1'h1) begin
      rxq.push_back(o_rx_data);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic wait_rx();
    for (int i = 0; i < 400 && rxq.size() == 0; i++) begin
      tick(1);
    end
    if (rxq.size() == 0) begin
      n_fail++;
      $display("Error at %0t: no byte received", $time);
      wrap_up();
    end
  endtask : wait_rx

  // One master word; a far slave left unselected returns a constant line.
  task automatic mst_word(input logic [1:0] f, input logic [7:0] tx, input logic [7:0] b);
    logic sel;
    sel = !(f[1] && f[0]);
    i_master_mode = 1'h1;
    i_select_mode_field = f;
    u_spi_far_end.sr = b;
    rxq.delete();
    tick(4);
    chk({7'h00, o_nss_pin_mapped}, {7'h00, f != SEL_3WIRE}, "pin map");
    i_tx_data = tx;
    i_tx_valid = 1'h1;
    tick(1);
    i_tx_valid = 1'h0;
    chk({7'h00, o_busy}, 8'h01, "busy");
    wait_rx();
    chk(rxq.pop_front(), sel ? b : {8{~b[7]}}, "master rx");
    chk(u_spi_far_end.sr, sel ? tx : b, "far rx");
  endtask : mst_word

  // Two slave bytes from the far master; the second shows the loaded word.
  task automatic slave_pass(input logic [1:0] f, input logic nss, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] s;
    logic       sel;
    sel = (f == SEL_3WIRE) || !nss;
    i_master_mode = 1'h0;
    i_select_mode_field = f;
    far_nss = nss;
    i_tx_data = b;
    i_tx_valid = 1'h1;
    rxq.delete();
    tick(6);
    for (int k = 0; k < 2; k++) begin
      s = 8'hC3 ^ 8'(k);
      u_spi_far_end.xfer(s, r);
      tick(8);
      if (sel) begin
        chk({7'h00, o_slave_selected}, 8'h01, "selected");
        wait_rx();
        chk(rxq.pop_front(), s, "slave rx");
        if (k == 1) chk(r, b, "slave tx");
      end else begin
        chk({6'h00, o_slave_selected, o_miso_oe} | 8'(rxq.size()), 8'h00, "unselected");
      end
    end
  endtask : slave_pass

  initial begin
    {i_sys_clk, i_spi_enable, i_master_mode, i_tx_valid, i_fault_clear} = 5'h00;
    {far_nss, slv_sel_n, i_sys_rst} = 3'h7;
    i_select_mode_field = SEL_3WIRE;
    i_tx_data = 8'h00;
    n_fail = 0;
    n_checks = 0;
    tick(2);
    i_sys_rst = 1'h0;
    i_spi_enable = 1'h1;
    slv_sel_n = 1'h0;
    // Master words in every select mode; mode 1x only ever as master.
    for (int f = 0; f < 4; f++) begin
      mst_word(2'(f), 8'h5A ^ 8'(f), 8'hB1 + 8'(f));
    end
    // A falling select in mode 01 stops the master until cleared.
    i_select_mode_field = SEL_4WIRE_IN;
    far_nss = 1'h0;
    tick(6);
    chk({5'h00, o_mode_fault, o_tx_ready, o_sck_oe}, 8'h04, "fault");
    far_nss = 1'h1;
    i_fault_clear = 1'h1;
    tick(1);
    i_fault_clear = 1'h0;
    chk({7'h00, o_mode_fault}, 8'h00, "fault clear");
    // The far master sends slave bytes in three wire mode and in mode 01, selected and unselected.
    slave_pass(SEL_3WIRE, 1'h1, 8'hA5);
    slave_pass(SEL_4WIRE_IN, 1'h0, 8'h3C);
    slave_pass(SEL_4WIRE_IN, 1'h1, 8'h96);
    i_tx_valid = 1'h0;
    i_spi_enable = 1'h0;
    tick(2);
    chk({7'h00, o_miso_oe}, 8'h00, "disabled float");
    wrap_up();
  end
endmodule : spi_pin_and_select_modes_test

bind spi_pin_and_select_modes spi_pins_props #(.SCK_HALF(SCK_HALF)) u_spi_pins_props (
  .i_sys_clk, .i_sys_rst, .i_spi_enable, .i_master_mode, .i_select_mode_field, .i_tx_data,
  .i_tx_valid, .i_nss, .o_tx_ready, .o_rx_valid, .o_busy, .o_slave_selected, .o_mode_fault,
  .o_nss_pin_mapped, .o_sck, .o_sck_oe, .o_mosi, .o_mosi_oe, .o_miso_oe, .o_nss, .o_nss_oe
);

`default_nettype wire

/* File: spi_pins_props.sv */
`default_nettype none

module spi_pins_props #(
  parameter int SCK_HALF = 4
) (
  // Clock, reset and inputs.
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_spi_enable,
  input wire logic       i_master_mode,
  input wire logic [1:0] i_select_mode_field,
  input wire logic [7:0] i_tx_data,
  input wire logic       i_tx_valid,
  input wire logic       i_nss,
  // Design outputs.
  input wire logic       o_tx_ready,
  input wire logic       o_rx_valid,
  input wire logic       o_busy,
  input wire logic       o_slave_selected,
  input wire logic       o_mode_fault,
  input wire logic       o_nss_pin_mapped,
  input wire logic       o_sck,
  input wire logic       o_sck_oe,
  input wire logic       o_mosi,
  input wire logic       o_mosi_oe,
  input wire logic       o_miso_oe,
  input wire logic       o_nss,
  input wire logic       o_nss_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import spi_pkg::*;

  localparam int HALF = SCK_HALF;
  logic       is_mst;
  logic [3:0] rise_cnt_reg;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Master role with the interface switched on.
  assign is_mst = i_spi_enable && i_master_mode;

  // Counts serial clock rises inside one master word.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !o_busy) begin
      rise_cnt_reg <= 4'h0;
    end else if ($rose(o_sck)) begin
      rise_cnt_reg <= rise_cnt_reg + 4'h1;
    end
  end

  // Pin directions, framing and select handling.
  mosi_dir_a: assert property (o_sck_oe == o_mosi_oe && o_mosi_oe == (is_mst && !o_mode_fault))
    else $error("mosi or sck enable wrong");
  first_bit_a: assert property (is_mst && i_tx_valid && o_tx_ready |=> o_mosi == $past(i_tx_data[7]))
    else $error("first bit is not the top bit");
  miso_dir_a: assert property (i_master_mode || !i_spi_enable |-> !o_miso_oe)
    else $error("miso driven when it must float");
  sck_half_a: assert property ($rose(o_sck) |-> ##HALF $fell(o_sck))
    else $error("serial clock high time wrong");
  word_len_a: assert property ($fell(o_busy) |-> rise_cnt_reg == 4'h8)
    else $error("word is not eight clocks");
  rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("receive flag longer than one cycle");
  three_wire_a: assert property (!i_master_mode && i_spi_enable && i_select_mode_field == SEL_3WIRE
    |-> o_slave_selected && o_miso_oe)
    else $error("three wire slave not selected");
  unselected_a: assert property (!i_master_mode && i_spi_enable && i_select_mode_field == SEL_4WIRE_IN
    && i_nss && $past(i_nss) && $past(i_nss, 2) && $past(i_nss, 3) && !$past(i_sys_rst, 3)
    |-> !o_slave_selected && !o_miso_oe)
    else $error("unselected slave active");
  mode_fault_a: assert property (is_mst && i_select_mode_field == SEL_4WIRE_IN && $fell(i_nss)
    |-> ##[1:4] o_mode_fault)
    else $error("select fall not flagged");
  nss_drive_a: assert property (o_nss_oe == (i_spi_enable && i_select_mode_field[SEL_HIGH_BIT])
    && (!o_nss_oe || o_nss == i_select_mode_field[SEL_LOW_BIT]))
    else $error("select output wrong");
  pin_map_a: assert property (o_nss_pin_mapped == (i_select_mode_field != SEL_3WIRE))
    else $error("select pin mapping wrong");

  master_word_c: cover property (o_rx_valid && i_master_mode);
  slave_word_c: cover property (o_rx_valid && !i_master_mode);
  fault_c: cover property ($rose(o_mode_fault));
endmodule : spi_pins_props

`default_nettype wire

/* File: spi_pkg.sv */
`default_nettype none

package spi_pkg;

  // Word geometry of the shift register.
  localparam int          WORD_BITS   = 8;
  localparam int          MSB_IDX     = WORD_BITS - 1;
  localparam int          CNT_W       = $clog2(WORD_BITS);
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [2:0]  FIRST_BIT   = 3'h0;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;

  // Select-mode field encodings and bit positions.
  localparam logic [1:0]  SEL_3WIRE    = 2'h0;
  localparam logic [1:0]  SEL_4WIRE_IN = 2'h1;
  localparam int          SEL_HIGH_BIT = 1;
  localparam int          SEL_LOW_BIT  = 0;

  // Serial clock timing for master operation.
  localparam int          SYS_CLK_PERIOD_NS = 8;
  localparam int          SCK_HALF_NS       = 64;
  localparam int          SCK_HALF_CYC      = (SCK_HALF_NS / SYS_CLK_PERIOD_NS < 1) ? 1 :
                                              SCK_HALF_NS / SYS_CLK_PERIOD_NS;

  // Synchroniser bit positions of the sampled inputs.
  localparam int          SYNC_W      = 3;
  localparam int          SYNC_MISO   = 0;
  localparam int          SYNC_NSS    = 1;
  localparam int          SYNC_DONE   = 2;

  // Master shift sequencer states.
  typedef enum logic [1:0] {
    M_IDLE,
    M_LOW,
    M_HIGH
  } master_state_e;

endpackage : spi_pkg

`default_nettype wire
